// *** smcd_pkg.sv ***
`default_nettype none
package smcd_pkg;
  // ----------------------------------------
  // opcodes and feature values
  // ----------------------------------------
  localparam logic [7:0] SMCD_OPC_SMART   = 8'hB0;
  localparam logic [7:0] SMCD_FT_RD_DATA  = 8'hD0;
  localparam logic [7:0] SMCD_FT_RD_THR   = 8'hD1;
  localparam logic [7:0] SMCD_FT_AUTOSAVE = 8'hD2;
  localparam logic [7:0] SMCD_FT_OFFLINE  = 8'hD4;
  localparam logic [7:0] SMCD_FT_RD_LOG   = 8'hD5;
  localparam logic [7:0] SMCD_FT_WR_LOG   = 8'hD6;
  localparam logic [7:0] SMCD_FT_ENABLE   = 8'hD8;
  localparam logic [7:0] SMCD_FT_DISABLE  = 8'hD9;
  localparam logic [7:0] SMCD_FT_STATUS   = 8'hDA;
  localparam logic [7:0] SMCD_AUTOSAVE_ON = 8'hF1;

  // ----------------------------------------
  // identify words and bit positions
  // ----------------------------------------
  localparam int SMCD_BIT_SUPPORT = 0;
  localparam int SMCD_BIT_SELFTST = 1;
  localparam int SMCD_BIT_ERRLOG  = 0;
  localparam int SMCD_BIT_ENABLE  = 0;

  // ----------------------------------------
  // attribute counters and timing
  // ----------------------------------------
  localparam int SMCD_CNT_W   = 32;
  localparam int SMCD_SLC_MIN = 3;
  localparam longint SMCD_CLK_HZ    = 250_000_000;
  localparam longint SMCD_HOUR_S    = 3600;
  localparam longint SMCD_HOUR_CYC  = SMCD_CLK_HZ * SMCD_HOUR_S;
  localparam logic [3:0] SMCD_SPARE_RST = 4'h0;

  typedef enum logic [3:0] {
    SMCD_OP_NONE, SMCD_OP_RD_DATA, SMCD_OP_RD_THR, SMCD_OP_AUTOSAVE,
    SMCD_OP_OFFLINE, SMCD_OP_RD_LOG, SMCD_OP_WR_LOG, SMCD_OP_ENABLE,
    SMCD_OP_DISABLE, SMCD_OP_STATUS
  } smcd_op_t;

  typedef struct packed {
    logic [15:0] w82;
    logic [15:0] w84;
    logic [15:0] w85;
    logic [15:0] w87;
  } smcd_ident_t;

  typedef struct packed {
    logic [31:0] a009_hours;
    logic [31:0] a012_cycles;
    logic [31:0] a013_soft;
    logic [31:0] a100_erase;
    logic [31:0] a170_spare;
    logic [31:0] a187_uncorr;
    logic [31:0] a188_tmo;
    logic [31:0] a199_crc;
  } smcd_attr_t;

  typedef struct packed {
    logic       cmd_vld;
    logic [7:0] opcode;
    logic [7:0] feature;
    logic [7:0] sector_cnt;
  } smcd_cmd_t;
endpackage
`default_nettype wire

// *** smcd_counter.sv ***
`default_nettype none
module smcd_counter
  import smcd_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  inc_i,
  output logic [SMCD_CNT_W-1:0]      cnt_o
);
  logic [SMCD_CNT_W-1:0] cnt_d;

  // saturate rather than wrap so a worn card never looks fresh
  always_comb
  begin
    cnt_d = cnt_o;
    if (inc_i && (cnt_o != {SMCD_CNT_W{1'b1}}))
    begin
      cnt_d = cnt_o + SMCD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_o <= '0;
    end
    else
    begin
      cnt_o <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// *** smcd_top.sv ***
// How it works
// - identify word 82 bit 0 reads one: self-monitoring supported
// - identify word 84 bit 1 reads one: self test supported
// - identify word 84 bit 0 reads zero: no error logging
// - monitoring enabled at reset, word 85 bit 0 set until disable
// - self test enabled at reset, word 87 bit 1 reads one
// - opcode B0 with feature value selects the self-monitoring operation
// - D0 attribute data, D1 thresholds, D2 autosave on or off
// - D4 off-line immediate, D5 read log, D6 write log
// - D8 enable, D9 disable and clear enable bit, DA status
// - count powered-on hours and power-on events
// - count reads corrected with three or more bits
// - count erase/program cycles; report spare block count
// - count uncorrectable interface errors and interrupted commands
// - count ultra dma crc errors
`default_nettype none
module smcd_top
  import smcd_pkg::*;
#(
  parameter longint HOUR_CYC = SMCD_HOUR_CYC
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire smcd_pkg::smcd_cmd_t cmd_i,
  input  wire logic              power_on_evt_i,
  input  wire logic              read_corr_i,
  input  wire logic [3:0]        corr_bits_i,
  input  wire logic              erase_prog_i,
  input  wire logic [31:0]       spare_blocks_i,
  input  wire logic              uncorr_err_i,
  input  wire logic              cmd_interrupted_i,
  input  wire logic              udma_crc_err_i,
  output logic                   done_o,
  output logic                   abort_o,
  output smcd_pkg::smcd_op_t     op_o,
  output logic                   autosave_o,
  output logic                   smart_en_o,
  output smcd_pkg::smcd_ident_t  ident_o,
  output smcd_pkg::smcd_attr_t   attr_o
);
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  smcd_op_t op_d;
  logic     done_d;
  logic     abort_d;
  logic     en_d;
  logic     as_d;
  logic     hit;

  always_comb
  begin
    op_d    = SMCD_OP_NONE;
    done_d  = 1'b0;
    abort_d = 1'b0;
    en_d    = smart_en_o;
    as_d    = autosave_o;
    hit     = cmd_i.cmd_vld && (cmd_i.opcode == SMCD_OPC_SMART);
    if (hit)
    begin
      case (cmd_i.feature)
        SMCD_FT_RD_DATA:  op_d = SMCD_OP_RD_DATA;
        SMCD_FT_RD_THR:   op_d = SMCD_OP_RD_THR;
        SMCD_FT_AUTOSAVE: op_d = SMCD_OP_AUTOSAVE;
        SMCD_FT_OFFLINE:  op_d = SMCD_OP_OFFLINE;
        SMCD_FT_RD_LOG:   op_d = SMCD_OP_RD_LOG;
        SMCD_FT_WR_LOG:   op_d = SMCD_OP_WR_LOG;
        SMCD_FT_ENABLE:   op_d = SMCD_OP_ENABLE;
        SMCD_FT_DISABLE:  op_d = SMCD_OP_DISABLE;
        SMCD_FT_STATUS:   op_d = SMCD_OP_STATUS;
        default:          op_d = SMCD_OP_NONE;
      endcase
      // other sub-commands are refused while monitoring is off
      if (op_d == SMCD_OP_NONE)
      begin
        abort_d = 1'b1;
      end
      else if (!smart_en_o && op_d != SMCD_OP_ENABLE)
      begin
        abort_d = 1'b1;
        op_d    = SMCD_OP_NONE;
      end
      else
      begin
        done_d = 1'b1;
      end
      if (done_d && op_d == SMCD_OP_ENABLE)
      begin
        en_d = 1'b1;
      end
      if (done_d && op_d == SMCD_OP_DISABLE)
      begin
        en_d = 1'b0;
      end
      if (done_d && op_d == SMCD_OP_AUTOSAVE)
      begin
        as_d = (cmd_i.sector_cnt == SMCD_AUTOSAVE_ON);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_o       <= SMCD_OP_NONE;
      done_o     <= 1'b0;
      abort_o    <= 1'b0;
      smart_en_o <= 1'b1;
      autosave_o <= 1'b0;
    end
    else
    begin
      op_o       <= op_d;
      done_o     <= done_d;
      abort_o    <= abort_d;
      smart_en_o <= en_d;
      autosave_o <= as_d;
    end
  end

  // ----------------------------------------
  // identify words
  // ----------------------------------------
  smcd_ident_t ident_d;

  always_comb
  begin
    ident_d = '0;
    ident_d.w82[SMCD_BIT_SUPPORT] = 1'b1;
    ident_d.w84[SMCD_BIT_SELFTST] = 1'b1;
    ident_d.w84[SMCD_BIT_ERRLOG]  = 1'b0;
    ident_d.w85[SMCD_BIT_ENABLE]  = en_d;
    ident_d.w87[SMCD_BIT_SELFTST] = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // static bits valid from plug in, not one clock after release
      ident_o                       <= '0;
      ident_o.w82[SMCD_BIT_SUPPORT] <= 1'b1;
      ident_o.w84[SMCD_BIT_SELFTST] <= 1'b1;
      ident_o.w85[SMCD_BIT_ENABLE]  <= 1'b1;
      ident_o.w87[SMCD_BIT_SELFTST] <= 1'b1;
    end
    else
    begin
      ident_o <= ident_d;
    end
  end

  // ----------------------------------------
  // hour tick
  // ----------------------------------------
  // wide counter; simulation shortens it through HOUR_CYC
  logic [39:0] hour_q;
  logic [39:0] hour_d;
  logic        hour_tick;

  always_comb
  begin
    hour_tick = (hour_q == 40'(HOUR_CYC - 1));
    hour_d    = hour_tick ? '0 : hour_q + 40'h00_0000_0001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hour_q <= '0;
    end
    else
    begin
      hour_q <= hour_d;
    end
  end

  // ----------------------------------------
  // attribute counters
  // ----------------------------------------
  logic [6:0] inc;
  logic [SMCD_CNT_W-1:0] cnt [7];

  always_comb
  begin
    inc[0] = hour_tick;
    inc[1] = power_on_evt_i;
    inc[2] = read_corr_i && (corr_bits_i >= 4'(SMCD_SLC_MIN));
    inc[3] = erase_prog_i;
    inc[4] = uncorr_err_i;
    inc[5] = cmd_interrupted_i;
    inc[6] = udma_crc_err_i;
  end

  for (genvar g = 0; g < 7; g++)
  begin : g_cnt
    smcd_counter u_cnt
    (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .inc_i   (inc[g]),
      .cnt_o   (cnt[g])
    );
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      attr_o <= '0;
    end
    else
    begin
      attr_o.a009_hours  <= cnt[0];
      attr_o.a012_cycles <= cnt[1];
      attr_o.a013_soft   <= cnt[2];
      attr_o.a100_erase  <= cnt[3];
      attr_o.a170_spare  <= spare_blocks_i;
      attr_o.a187_uncorr <= cnt[4];
      attr_o.a188_tmo    <= cnt[5];
      attr_o.a199_crc    <= cnt[6];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_SUPPORT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 ident_o.w82[SMCD_BIT_SUPPORT]) else $error("support bit low");
  AST_SELFTEST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 ident_o.w84[SMCD_BIT_SELFTST] && ident_o.w87[SMCD_BIT_SELFTST])
    else $error("self test bits low");
  AST_NOLOG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ident_o.w84[SMCD_BIT_ERRLOG]) else $error("error log bit set");
  AST_DISABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_o && op_o == SMCD_OP_DISABLE |-> !smart_en_o
      && !ident_o.w85[SMCD_BIT_ENABLE]) else $error("disable missed");
  AST_ENABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_i.cmd_vld && cmd_i.opcode == SMCD_OPC_SMART
      && cmd_i.feature == SMCD_FT_ENABLE |=> smart_en_o && done_o)
    else $error("enable missed");
  AST_DECODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    smart_en_o && cmd_i.cmd_vld && cmd_i.opcode == SMCD_OPC_SMART
      && cmd_i.feature == SMCD_FT_RD_DATA |=> op_o == SMCD_OP_RD_DATA)
    else $error("read data not decoded");
  AST_ABORT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_i.cmd_vld && cmd_i.opcode == SMCD_OPC_SMART
      && cmd_i.feature == 8'hD3 |=> abort_o && !done_o)
    else $error("bad feature not aborted");
  AST_CRC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    udma_crc_err_i && cnt[6] != '1 |=> ##1 attr_o.a199_crc
      == $past(attr_o.a199_crc) + 32'h0000_0001)
    else $error("crc count missed");
endmodule
`default_nettype wire

// *** smcd_host.sv ***
`default_nettype none
module smcd_host
  import smcd_pkg::*;
(
  input  wire logic                clk_i,
  output var  smcd_pkg::smcd_cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // task-file writer
  // ----------------------------------------
  initial cmd_o = '0;

  // released fields show inverted data, so stale values never match
  task automatic send(input logic [7:0] opc, input logic [7:0] ft,
                      input logic [7:0] sc);
    @(posedge clk_i);
    cmd_o <= '{cmd_vld: 1'b1, opcode: opc, feature: ft, sector_cnt: sc};
    @(posedge clk_i);
    cmd_o <= '{cmd_vld: 1'b0, opcode: ~opc, feature: ~ft, sector_cnt: ~sc};
  endtask
endmodule
`default_nettype wire

// *** smart_command_decoder_tb.sv ***
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module smart_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smcd_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_i;
  logic        rst_n_i;
  smcd_cmd_t   cmd;
  logic [4:0]  ev;
  logic        rd_corr;
  logic [3:0]  corr_bits;
  logic [31:0] spare;
  logic [31:0] h0;
  logic        done_o;
  logic        abort_o;
  smcd_op_t    op_o;
  logic        autosave_o;
  logic        smart_en_o;
  smcd_ident_t ident_o;
  smcd_attr_t  attr_o;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [7:0]  ft_tab [8] = '{8'hD0, 8'hD1, 8'hD2, 8'hD4, 8'hD5, 8'hD6,
                              8'hD8, 8'hDA};
  smcd_op_t    op_tab [8] = '{SMCD_OP_RD_DATA, SMCD_OP_RD_THR,
    SMCD_OP_AUTOSAVE, SMCD_OP_OFFLINE, SMCD_OP_RD_LOG, SMCD_OP_WR_LOG,
    SMCD_OP_ENABLE, SMCD_OP_STATUS};

  smcd_host u_host (.clk_i(clk_i), .cmd_o(cmd));

  // short hour so the hour counter is seen moving
  smcd_top #(.HOUR_CYC(10)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
    .power_on_evt_i(ev[0]), .read_corr_i(rd_corr), .corr_bits_i(corr_bits),
    .erase_prog_i(ev[1]), .spare_blocks_i(spare), .uncorr_err_i(ev[2]),
    .cmd_interrupted_i(ev[3]), .udma_crc_err_i(ev[4]),
    .done_o(done_o), .abort_o(abort_o), .op_o(op_o),
    .autosave_o(autosave_o), .smart_en_o(smart_en_o),
    .ident_o(ident_o), .attr_o(attr_o));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmd_chk(input logic [7:0] ft, input logic [7:0] sc,
                         input logic ok, input smcd_op_t op);
    u_host.send(SMCD_OPC_SMART, ft, sc);
    #1;
    `CHK("done", ok, done_o)
    `CHK("abort", ~ok, abort_o)
    `CHK("op", op, op_o)
  endtask

  task automatic pulse(input int i, input logic [3:0] b);
    @(posedge clk_i);
    if (i < 5) ev <= 5'(1 << i);
    else rd_corr <= 1'b1;
    corr_bits <= b;
    @(posedge clk_i);
    ev <= '0;
    rd_corr <= 1'b0;
  endtask

  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #20000;
    num_errors++;
    conclude();
  end

  initial
  begin
    rst_n_i = 1'b0;
    ev = '0;
    rd_corr = 1'b0;
    corr_bits = 4'h0;
    spare = 32'h0000_0042;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("w82b0", 1'b1, ident_o.w82[0])
    `CHK("w84b1", 1'b1, ident_o.w84[1])
    `CHK("w84b0", 1'b0, ident_o.w84[0])
    `CHK("w85b0", 1'b1, ident_o.w85[0])
    `CHK("w87b1", 1'b1, ident_o.w87[1])
    for (int i = 0; i < 8; i++)
      cmd_chk(ft_tab[i], 8'h00, 1'b1, op_tab[i]);
    cmd_chk(8'hD9, 8'h00, 1'b1, SMCD_OP_DISABLE);
    `CHK("w85_off", 1'b0, ident_o.w85[0])
    `CHK("en_off", 1'b0, smart_en_o)
    cmd_chk(8'hD0, 8'h00, 1'b0, SMCD_OP_NONE);
    cmd_chk(8'hD8, 8'h00, 1'b1, SMCD_OP_ENABLE);
    `CHK("w85_on", 1'b1, ident_o.w85[0])
    cmd_chk(8'hD3, 8'h00, 1'b0, SMCD_OP_NONE);
    cmd_chk(8'hDB, 8'h00, 1'b0, SMCD_OP_NONE);
    cmd_chk(8'hD2, 8'hF1, 1'b1, SMCD_OP_AUTOSAVE);
    `CHK("as_on", 1'b1, autosave_o)
    cmd_chk(8'hD2, 8'h00, 1'b1, SMCD_OP_AUTOSAVE);
    `CHK("as_off", 1'b0, autosave_o)
    u_host.send(8'hEC, 8'hD0, 8'h00);
    #1;
    `CHK("other_op", 2'b00, {done_o, abort_o})
    for (int i = 0; i < 5; i++)
      for (int n = 0; n <= i; n++) pulse(i, 4'h0);
    pulse(5, 4'h2);
    pulse(5, 4'h3);
    pulse(5, 4'hF);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("a012", 32'h0000_0001, attr_o.a012_cycles)
    `CHK("a013", 32'h0000_0002, attr_o.a013_soft)
    `CHK("a100", 32'h0000_0002, attr_o.a100_erase)
    `CHK("a170", 32'h0000_0042, attr_o.a170_spare)
    `CHK("a187", 32'h0000_0003, attr_o.a187_uncorr)
    `CHK("a188", 32'h0000_0004, attr_o.a188_tmo)
    `CHK("a199", 32'h0000_0005, attr_o.a199_crc)
    h0 = attr_o.a009_hours;
    repeat (10) @(posedge clk_i);
    #1;
    `CHK("a009", h0 + 32'h0000_0001, attr_o.a009_hours)
    // a second plug in must bring monitoring back after a disable
    cmd_chk(8'hD9, 8'h00, 1'b1, SMCD_OP_DISABLE);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK("w85_plug", 1'b1, ident_o.w85[0])
    `CHK("en_plug", 1'b1, smart_en_o)
    `CHK("w87_plug", 1'b1, ident_o.w87[1])
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
